// >>> hdl/dict_clkgen.sv
// machine cycle strobe from the input clock, divide by two or by one
`timescale 1ns/1ps
`default_nettype none
module dict_clkgen (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // strobe bus
   dict_if.clkgen    cg
);
   typedef struct packed {
      logic phase;
      logic tick;
   } dict_cg_t;

   dict_cg_t cg_reg;
   dict_cg_t cg_next;

   // phase starts at zero on every reset, so several parts share one alignment
   always_comb begin
      cg_next = cg_reg;
      if (cg.div1) begin
         cg_next.phase = 1'b0;
         cg_next.tick  = 1'b1;
      end else begin
         cg_next.phase = ~cg_reg.phase;
         cg_next.tick  = cg_reg.phase;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cg_reg <= '0;
      end else begin
         cg_reg <= cg_next;
      end
   end

   assign cg.tick     = cg_reg.tick;
   assign cg.phase    = cg_reg.phase;
   assign cg.tickNext = cg_next.tick;
endmodule // dict_clkgen
`default_nettype wire

// >>> hdl/dict_decode.sv
// instruction class lookup: words, machine cycles and operand use per instruction
`timescale 1ns/1ps
`default_nettype none
`include "dict_map.svh"
module dict_decode #(
   parameter logic [2:0] TRAP_CYCLES = 3'(`DICT_PIPE_STAGES)
) (
   // lookup
   dict_if.decoder dec
);
   dict_pkg::dict_info_t i;

   always_comb begin
      i = '0;
      i.known  = 1'b1;
      i.words  = `DICT_W1;
      i.cycles = `DICT_C1;
      case (dec.op)
         // plain one-word one-cycle operations without memory operand
         dict_pkg::OP_MINUS_PRODUCT_FROM_ACC,
         dict_pkg::OP_EXCLUSIVE_OR_ACC_BUFFER,
         dict_pkg::OP_ZERO_ACC_AND_PRODUCT,
         dict_pkg::OP_ZERO_PRODUCT_REG: begin
            i.known = 1'b1;
         end
         dict_pkg::OP_SET_PRODUCT_SHIFT,
         dict_pkg::OP_MINUS_SHORT_IMM,
         dict_pkg::OP_CONDITIONAL_EXECUTE: begin
            i.noRepeat = 1'b1;
         end
         dict_pkg::OP_SQUARE_ACCUMULATE,
         dict_pkg::OP_SQUARE_MINUS,
         dict_pkg::OP_MINUS_MEM,
         dict_pkg::OP_MINUS_WITH_BORROW,
         dict_pkg::OP_CONDITIONAL_MINUS_STEP,
         dict_pkg::OP_MINUS_SIGN_EXT_SUPPRESSED,
         dict_pkg::OP_MINUS_SHIFT_BY_TREG,
         dict_pkg::OP_EXCLUSIVE_OR_MEM,
         dict_pkg::OP_ZERO_LOAD_HIGH_ROUND: begin
            i.memRd = 1'b1;
         end
         dict_pkg::OP_STORE_PRODUCT_HIGH,
         dict_pkg::OP_STORE_PRODUCT_LOW,
         dict_pkg::OP_STORE_STATUS: begin
            i.memWr = 1'b1;
         end
         dict_pkg::OP_STORE_LONG_CONSTANT: begin
            i.words    = `DICT_W2;
            i.cycles   = `DICT_C2;
            i.memWr    = 1'b1;
            i.noRepeat = 1'b1;
         end
         dict_pkg::OP_MINUS_LONG_IMM,
         dict_pkg::OP_EXCLUSIVE_OR_LONG_IMM: begin
            i.words    = `DICT_W2;
            i.cycles   = `DICT_C2;
            i.noRepeat = 1'b1;
         end
         // table read lands in data memory, table write reads it
         dict_pkg::OP_TABLE_READ: begin
            i.cycles = `DICT_C3;
            i.memWr  = 1'b1;
         end
         dict_pkg::OP_TABLE_WRITE: begin
            i.cycles = `DICT_C3;
            i.memRd  = 1'b1;
         end
         dict_pkg::OP_SOFTWARE_TRAP: begin
            i.cycles   = TRAP_CYCLES;
            i.noRepeat = 1'b1;
            i.pcBreak  = 1'b1;
         end
         dict_pkg::OP_EXCLUSIVE_OR_INTO_DATA: begin
            i.memRd = 1'b1;
            i.memWr = 1'b1;
         end
         dict_pkg::OP_EXCLUSIVE_OR_INTO_DATA_LK: begin
            i.words  = `DICT_W2;
            i.cycles = `DICT_C2;
            i.memRd  = 1'b1;
            i.memWr  = 1'b1;
         end
         // unknown codes still take a slot so the fetch path never hangs
         default: begin
            i.known = 1'b0;
         end
      endcase
   end

   assign dec.info = i;
endmodule // dict_decode
`default_nettype wire

// >>> hdl/dict_if.sv
// signals between the sequencer, the decoder and the clock generator
`timescale 1ns/1ps
`default_nettype none
interface dict_if;
   dict_pkg::dict_op_t   op;
   dict_pkg::dict_info_t info;
   logic                 div1;
   logic                 tick;
   logic                 tickNext;
   logic                 phase;

   modport decoder (input op, output info);
   modport clkgen  (input div1, output tick, tickNext, phase);
   modport core    (output op, div1, input info, tick, tickNext, phase);
endinterface
`default_nettype wire

// >>> hdl/dict_map.svh
// constants of the instruction timing block: counts, widths and clock figures
`ifndef DICT_MAP_SVH
`define DICT_MAP_SVH

// input clock figures
`define DICT_CORE_CLK_MHZ 20
`define DICT_CORE_CLK_NS  50

// pipeline depth, also the cost of a discontinuity without delay slots
`define DICT_PIPE_STAGES  4

// instruction word counts
`define DICT_W1 2'h1
`define DICT_W2 2'h2

// machine cycle counts
`define DICT_C1 3'h1
`define DICT_C2 3'h2
`define DICT_C3 3'h3

// reset values
`define DICT_HOLD_RST  3'h0
`define DICT_SYNC_RST  2'h0

`endif

// >>> hdl/dict_pkg.sv
// types shared by the instruction timing modules
`default_nettype none
package dict_pkg;

   typedef enum logic [4:0] {
      OP_IDLE                      = 5'h00,
      OP_MINUS_PRODUCT_FROM_ACC    = 5'h01,
      OP_EXCLUSIVE_OR_ACC_BUFFER   = 5'h02,
      OP_ZERO_ACC_AND_PRODUCT      = 5'h03,
      OP_ZERO_PRODUCT_REG          = 5'h04,
      OP_SET_PRODUCT_SHIFT         = 5'h05,
      OP_MINUS_SHORT_IMM           = 5'h06,
      OP_CONDITIONAL_EXECUTE       = 5'h07,
      OP_SQUARE_ACCUMULATE         = 5'h08,
      OP_SQUARE_MINUS              = 5'h09,
      OP_MINUS_MEM                 = 5'h0A,
      OP_MINUS_WITH_BORROW         = 5'h0B,
      OP_CONDITIONAL_MINUS_STEP    = 5'h0C,
      OP_MINUS_SIGN_EXT_SUPPRESSED = 5'h0D,
      OP_MINUS_SHIFT_BY_TREG       = 5'h0E,
      OP_EXCLUSIVE_OR_MEM          = 5'h0F,
      OP_ZERO_LOAD_HIGH_ROUND      = 5'h10,
      OP_STORE_PRODUCT_HIGH        = 5'h11,
      OP_STORE_PRODUCT_LOW         = 5'h12,
      OP_STORE_STATUS              = 5'h13,
      OP_STORE_LONG_CONSTANT       = 5'h14,
      OP_MINUS_LONG_IMM            = 5'h15,
      OP_EXCLUSIVE_OR_LONG_IMM     = 5'h16,
      OP_TABLE_READ                = 5'h17,
      OP_TABLE_WRITE               = 5'h18,
      OP_SOFTWARE_TRAP             = 5'h19,
      OP_EXCLUSIVE_OR_INTO_DATA    = 5'h1A,
      OP_EXCLUSIVE_OR_INTO_DATA_LK = 5'h1B
   } dict_op_t;

   typedef struct packed {
      logic       known;
      logic [1:0] words;
      logic [2:0] cycles;
      logic       memRd;
      logic       memWr;
      logic       noRepeat;
      logic       pcBreak;
   } dict_info_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_HOLD = 2'b01
   } dict_seq_t;

   typedef struct packed {
      logic     valid;
      dict_op_t op;
   } dict_stage_t;

endpackage
`default_nettype wire

// >>> hdl/dict_top.sv
// instruction issue sequencer with four-stage pipeline tracking and machine clock
// Notes on behaviour
// - instructions move through a pipeline four stages deep; discontinuity costs four
// - default mode: one machine cycle per two input clocks, two phases
// - optional mode: machine cycle rate equals input clock rate
// - reset sets the divider phase, so parts align without a sync input
// - accumulator/product/buffer ops without memory: one word, one cycle
// - product shift, short subtract, conditional execute: one word, one cycle, no repeat
// - single memory read ops: one word, one cycle
// - single memory write stores: one word, one cycle
// - long constant store: two words, two cycles, not repeatable
// - long immediate subtract and xor: two words, two cycles, no memory, no repeat
// - table read: one word, three cycles
// - table write: one word, three cycles
// - software trap: one word, four cycles, discontinuity, not repeatable
// - short xor into data: read and write, one word, one cycle
// - long xor into data: read and write, two words, two cycles
`timescale 1ns/1ps
`default_nettype none
`include "dict_map.svh"
module dict_top #(
   parameter int STAGES = `DICT_PIPE_STAGES
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   // clock mode pin, high selects divide by one
   input  wire logic                 clkDivOnePin,
   // fetch path
   input  wire logic                 instrValid,
   input  wire dict_pkg::dict_op_t   instrOp,
   input  wire logic                 repeatPending,
   output logic                      instrReady,
   // machine clock
   output logic                      machTick,
   output logic                      machPhase,
   // issue report
   output logic                      issuePulse,
   output logic [1:0]                issueWords,
   output logic [2:0]                issueCycles,
   output logic                      memReadStrobe,
   output logic                      memWriteStrobe,
   output logic                      pcBreakPulse,
   output logic                      repeatFault,
   output logic                      unknownOp,
   // pipeline view
   output logic [STAGES-1:0]         stageValid,
   output dict_pkg::dict_op_t        execOp
);
   // the hold counter is three bits wide, so the trap cost cannot exceed seven
   if (STAGES < 2 || STAGES > 7) begin : g_bad_stages
      $error("dict_top: STAGES must lie between 2 and 7");
   end

   typedef struct packed {
      dict_pkg::dict_seq_t               seq;
      logic [2:0]                        hold;
      logic                              ready;
      logic                              issue;
      logic [1:0]                        words;
      logic [2:0]                        cycles;
      logic                              memRd;
      logic                              memWr;
      logic                              pcBreak;
      logic                              repFault;
      logic                              unknown;
      logic [1:0]                        modeSync;
      dict_pkg::dict_stage_t [STAGES-1:0] pipe;
   } dict_core_t;

   dict_core_t st_reg;
   dict_core_t st_next;
   logic       take;

   dict_if bus ();

   dict_decode #(
      .TRAP_CYCLES (3'(STAGES))
   ) u_decode (
      .dec (bus.decoder)
   );

   dict_clkgen u_clkgen (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .cg       (bus.clkgen)
   );

   assign bus.op   = instrOp;
   assign bus.div1 = st_reg.modeSync[1];
   // ready is only raised for an edge that ends a machine cycle
   assign take     = st_reg.ready && instrValid;

   always_comb begin
      st_next          = st_reg;
      st_next.issue    = 1'b0;
      st_next.memRd    = 1'b0;
      st_next.memWr    = 1'b0;
      st_next.pcBreak  = 1'b0;
      st_next.repFault = 1'b0;
      st_next.unknown  = 1'b0;
      st_next.modeSync = {st_reg.modeSync[0], clkDivOnePin};
      if (bus.tick) begin
         for (int k = STAGES - 1; k > 0; k--) begin
            st_next.pipe[k] = st_reg.pipe[k-1];
         end
         st_next.pipe[0].valid = take;
         st_next.pipe[0].op    = take ? instrOp : dict_pkg::OP_IDLE;
         case (st_reg.seq)
            dict_pkg::SEQ_IDLE: begin
               if (take) begin
                  st_next.issue    = 1'b1;
                  st_next.words    = bus.info.words;
                  st_next.cycles   = bus.info.cycles;
                  st_next.memRd    = bus.info.memRd;
                  st_next.memWr    = bus.info.memWr;
                  st_next.pcBreak  = bus.info.pcBreak;
                  st_next.unknown  = ~bus.info.known;
                  // executes once; the repeat count is left to the core
                  st_next.repFault = bus.info.noRepeat && repeatPending;
                  if (bus.info.cycles > `DICT_C1) begin
                     st_next.seq  = dict_pkg::SEQ_HOLD;
                     st_next.hold = bus.info.cycles - `DICT_C1;
                  end
               end
            end
            dict_pkg::SEQ_HOLD: begin
               st_next.hold = st_reg.hold - `DICT_C1;
               if (st_reg.hold == `DICT_C1) begin
                  st_next.seq = dict_pkg::SEQ_IDLE;
               end
            end
            default: begin
               st_next.seq  = dict_pkg::SEQ_IDLE;
               st_next.hold = `DICT_HOLD_RST;
            end
         endcase
      end
      st_next.ready = (st_next.seq == dict_pkg::SEQ_IDLE) && bus.tickNext;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg          <= '0;
         st_reg.seq      <= dict_pkg::SEQ_IDLE;
         st_reg.hold     <= `DICT_HOLD_RST;
         st_reg.modeSync <= `DICT_SYNC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign instrReady     = st_reg.ready;
   assign machTick       = bus.tick;
   assign machPhase      = bus.phase;
   assign issuePulse     = st_reg.issue;
   assign issueWords     = st_reg.words;
   assign issueCycles    = st_reg.cycles;
   assign memReadStrobe  = st_reg.memRd;
   assign memWriteStrobe = st_reg.memWr;
   assign pcBreakPulse   = st_reg.pcBreak;
   assign repeatFault    = st_reg.repFault;
   assign unknownOp      = st_reg.unknown;
   assign execOp         = st_reg.pipe[STAGES-1].op;

   for (genvar g = 0; g < STAGES; g++) begin : g_stage
      assign stageValid[g] = st_reg.pipe[g].valid;
   end

   // checks: helper counts edges since reset release
   logic [1:0] relCnt;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         relCnt <= 2'h0;
      end else if (relCnt != 2'h3) begin
         relCnt <= relCnt + 2'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_pipe_shift: assert property ((machTick && st_reg.pipe[0].valid)
      |=> (st_reg.pipe[1] == $past(st_reg.pipe[0])))
      else $error("pipeline stage did not advance");
   a_pipe_still: assert property (!machTick
      |=> (stageValid == $past(stageValid)))
      else $error("pipeline moved without a machine tick");
   a_exec_reach: assert property ((machTick && st_reg.pipe[STAGES-2].valid)
      |=> stageValid[STAGES-1])
      else $error("execute stage not reached");
   a_exec_bubble: assert property (!stageValid[STAGES-1]
      |-> (execOp == dict_pkg::OP_IDLE))
      else $error("bubble carries an opcode");
   a_half_rate: assert property ((!bus.div1 && $past(!bus.div1) && machTick)
      |=> !machTick ##1 machTick)
      else $error("divide by two strobe out of pattern");
   a_full_rate: assert property ((bus.div1 && $past(bus.div1)) |-> machTick)
      else $error("divide by one strobe missing");
   a_full_phase: assert property ((bus.div1 && $past(bus.div1))
      |-> !machPhase)
      else $error("divide by one phase not held low");
   a_reset_phase: assert property ((relCnt == 2'h1)
      |-> (machPhase && !machTick))
      else $error("divider phase not set by reset");
   a_class_plain: assert property ((take && instrOp inside {
         dict_pkg::OP_MINUS_PRODUCT_FROM_ACC, dict_pkg::OP_EXCLUSIVE_OR_ACC_BUFFER,
         dict_pkg::OP_ZERO_ACC_AND_PRODUCT, dict_pkg::OP_ZERO_PRODUCT_REG})
      |=> (issueWords == `DICT_W1 && issueCycles == `DICT_C1
           && !memReadStrobe && !memWriteStrobe && !repeatFault))
      else $error("plain op timing wrong");
   a_class_norep: assert property ((take && repeatPending && instrOp inside {
         dict_pkg::OP_SET_PRODUCT_SHIFT, dict_pkg::OP_MINUS_SHORT_IMM,
         dict_pkg::OP_CONDITIONAL_EXECUTE})
      |=> (issueCycles == `DICT_C1 && repeatFault && instrReady == $past(bus.tickNext, 1)))
      else $error("short non-repeatable op wrong");
   a_class_read: assert property ((take && instrOp inside {
         dict_pkg::OP_SQUARE_ACCUMULATE, dict_pkg::OP_SQUARE_MINUS, dict_pkg::OP_MINUS_MEM,
         dict_pkg::OP_MINUS_WITH_BORROW, dict_pkg::OP_CONDITIONAL_MINUS_STEP,
         dict_pkg::OP_MINUS_SIGN_EXT_SUPPRESSED, dict_pkg::OP_MINUS_SHIFT_BY_TREG,
         dict_pkg::OP_EXCLUSIVE_OR_MEM, dict_pkg::OP_ZERO_LOAD_HIGH_ROUND})
      |=> (issueCycles == `DICT_C1 && memReadStrobe && !memWriteStrobe))
      else $error("memory read op timing wrong");
   a_strobe_issue: assert property ((memReadStrobe || memWriteStrobe || pcBreakPulse
         || repeatFault || unknownOp) |-> issuePulse)
      else $error("strobe without an issue");
   a_class_write: assert property ((take && instrOp inside {
         dict_pkg::OP_STORE_PRODUCT_HIGH, dict_pkg::OP_STORE_PRODUCT_LOW,
         dict_pkg::OP_STORE_STATUS})
      |=> (issueCycles == `DICT_C1 && memWriteStrobe && !memReadStrobe))
      else $error("memory write op timing wrong");
   a_long_store: assert property ((take
         && instrOp == dict_pkg::OP_STORE_LONG_CONSTANT)
      |=> (issueWords == `DICT_W2 && issueCycles == `DICT_C2 && memWriteStrobe))
      else $error("long constant store timing wrong");
   a_long_imm: assert property ((take && instrOp inside {
         dict_pkg::OP_MINUS_LONG_IMM, dict_pkg::OP_EXCLUSIVE_OR_LONG_IMM})
      |=> (issueWords == `DICT_W2 && issueCycles == `DICT_C2
           && !memReadStrobe && !memWriteStrobe))
      else $error("long immediate timing wrong");
   a_table_read: assert property ((take && instrOp == dict_pkg::OP_TABLE_READ)
      |=> (issueWords == `DICT_W1 && issueCycles == `DICT_C3))
      else $error("table read timing wrong");
   a_table_write: assert property ((take && instrOp == dict_pkg::OP_TABLE_WRITE)
      |=> (issueWords == `DICT_W1 && issueCycles == `DICT_C3))
      else $error("table write timing wrong");
   a_trap_hold: assert property ((take && instrOp == dict_pkg::OP_SOFTWARE_TRAP
         && bus.div1 && $past(bus.div1))
      |=> (pcBreakPulse && issueCycles == 3'(STAGES)) ##0 !instrReady[*3] ##1 instrReady)
      else $error("trap did not hold issue for its cycles");
   a_trap_break: assert property ((take && instrOp == dict_pkg::OP_SOFTWARE_TRAP)
      |=> (pcBreakPulse && issueWords == `DICT_W1 && repeatFault == $past(repeatPending)))
      else $error("trap report wrong");
   a_no_break: assert property ((take && instrOp != dict_pkg::OP_SOFTWARE_TRAP)
      |=> !pcBreakPulse)
      else $error("break reported for a plain op");
   a_xor_short: assert property ((take
         && instrOp == dict_pkg::OP_EXCLUSIVE_OR_INTO_DATA)
      |=> (issueWords == `DICT_W1 && issueCycles == `DICT_C1
           && memReadStrobe && memWriteStrobe))
      else $error("short xor into data wrong");
   a_xor_long: assert property ((take
         && instrOp == dict_pkg::OP_EXCLUSIVE_OR_INTO_DATA_LK)
      |=> (issueWords == `DICT_W2 && issueCycles == `DICT_C2
           && memReadStrobe && memWriteStrobe))
      else $error("long xor into data wrong");
   a_issue_hold: assert property ((issuePulse && issueCycles > `DICT_C1)
      |-> !instrReady)
      else $error("issue not held for extra cycles");
   a_hold_ready: assert property ((st_reg.seq == dict_pkg::SEQ_HOLD)
      |-> !instrReady)
      else $error("ready raised while holding");
   a_take_tick: assert property (take |-> machTick)
      else $error("instruction taken off a machine cycle end");
   a_words_stand: assert property (!issuePulse
      |-> ($stable(issueWords) && $stable(issueCycles)))
      else $error("class report changed without an issue");
   a_unknown_op: assert property ((take && !(instrOp inside {
         [dict_pkg::OP_MINUS_PRODUCT_FROM_ACC:dict_pkg::OP_EXCLUSIVE_OR_INTO_DATA_LK]}))
      |=> (unknownOp && issueWords == `DICT_W1 && issueCycles == `DICT_C1))
      else $error("unknown code not issued as one cycle");
   a_repeat_fault: assert property ((take && bus.info.noRepeat && repeatPending)
      |=> (repeatFault && issuePulse))
      else $error("non-repeatable op under repeat not reported");
   a_repeat_quiet: assert property ((take && !repeatPending)
      |=> !repeatFault)
      else $error("repeat fault without a pending repeat");

   c_trap: cover property (take && instrOp == dict_pkg::OP_SOFTWARE_TRAP);
   c_table: cover property (take && instrOp == dict_pkg::OP_TABLE_READ ##1 issuePulse);
   c_back2back: cover property (take ##1 take);
   c_fault: cover property (repeatFault);
   c_div_one: cover property (bus.div1 && take);
endmodule // dict_top
`default_nettype wire

// >>> tb/dict_top_tb_top.sv
// self-checking bench for the instruction timing block
`timescale 1ns/1ps
`default_nettype none
module dict_top_tb_top;
   localparam int STG = 4;

   // clock and reset
   logic               core_clk = 1'b0;
   logic               reset_n;
   // stimulus
   logic               clkDivOnePin;
   logic               instrValid;
   dict_pkg::dict_op_t instrOp;
   logic               repeatPending;
   // observed
   logic               instrReady;
   logic               machTick;
   logic               machPhase;
   logic               issuePulse;
   logic [1:0]         issueWords;
   logic [2:0]         issueCycles;
   logic               memReadStrobe;
   logic               memWriteStrobe;
   logic               pcBreakPulse;
   logic               repeatFault;
   logic               unknownOp;
   logic [STG-1:0]     stageValid;
   dict_pkg::dict_op_t execOp;
   int                 err_count = 0;
   int                 total_checks = 0;
   int                 div = 2;

   dict_top #(.STAGES(STG)) u_dict_top (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .clkDivOnePin   (clkDivOnePin),
      .instrValid     (instrValid),
      .instrOp        (instrOp),
      .repeatPending  (repeatPending),
      .instrReady     (instrReady),
      .machTick       (machTick),
      .machPhase      (machPhase),
      .issuePulse     (issuePulse),
      .issueWords     (issueWords),
      .issueCycles    (issueCycles),
      .memReadStrobe  (memReadStrobe),
      .memWriteStrobe (memWriteStrobe),
      .pcBreakPulse   (pcBreakPulse),
      .repeatFault    (repeatFault),
      .unknownOp      (unknownOp),
      .stageValid     (stageValid),
      .execOp         (execOp)
   );

   always #25 core_clk = ~core_clk;

   task automatic check(input bit ok, input string msg);
      total_checks++;
      if (!ok) begin
         err_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic stop_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // expected class per opcode index: {words, cycles, read, write, break, non-repeatable}
   function automatic logic [8:0] exp_of(input int i);
      logic [8:0] e;
      e = {2'h1, 3'h1, 4'h0};
      if (i >= 5 && i <= 7) e[0] = 1'b1;
      if ((i >= 8 && i <= 16) || i == 24 || i == 26 || i == 27) e[3] = 1'b1;
      if ((i >= 17 && i <= 20) || i == 23 || i == 26 || i == 27) e[2] = 1'b1;
      if ((i >= 20 && i <= 22) || i == 27) e[8:4] = {2'h2, 3'h2};
      if (i >= 20 && i <= 22) e[0] = 1'b1;
      if (i == 23 || i == 24) e[6:4] = 3'h3;
      if (i == 25) e = {2'h1, 3'(STG), 4'b0011};
      return e;
   endfunction

   task automatic wait_ready();
      int n;
      n = 0;
      while (instrReady !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         #5;
         n++;
      end
   endtask

   // takes one instruction, judges its class outputs and how long issue is held
   task automatic issue(input int i, input logic rep);
      logic [8:0] e;
      int         n;
      e = exp_of(i);
      wait_ready();
      instrValid = 1'b1;
      instrOp = dict_pkg::dict_op_t'(i[4:0]);
      repeatPending = rep;
      @(posedge core_clk);
      #5;
      instrValid = 1'b0;
      repeatPending = 1'b0;
      check(issuePulse === 1'b1 && issueWords === e[8:7] && issueCycles === e[6:4], "class");
      check(memReadStrobe === e[3] && memWriteStrobe === e[2], "memory strobes");
      check(pcBreakPulse === e[1] && unknownOp === (i == 28), "break or unknown");
      check(repeatFault === (rep & e[0]), "repeat report");
      n = 1;
      while (instrReady !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         #5;
         n++;
      end
      check(n == int'(e[6:4]) * div, "issue hold length");
   endtask

   task automatic t_reset();
      reset_n = 1'b0;
      repeat (10) @(posedge core_clk);
      #5;
      check(machTick === 1'b0 && instrReady === 1'b0 && issuePulse === 1'b0, "reset outputs");
      reset_n = 1'b1;
      @(posedge core_clk);
      #5;
      check(machPhase === 1'b1 && machTick === 1'b0 && instrReady === 1'b0, "first edge");
      @(posedge core_clk);
      #5;
      check(machTick === 1'b1 && instrReady === 1'b1, "second edge");
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         #5;
         check(machTick === k[0], "divide by two tick");
      end
      div = 2;
   endtask

   task automatic t_div_one();
      clkDivOnePin = 1'b1;
      repeat (6) @(posedge core_clk);
      #5;
      for (int k = 0; k < 3; k++) begin
         check(machTick === 1'b1 && machPhase === 1'b0, "divide by one tick");
         @(posedge core_clk);
         #5;
      end
      div = 1;
   endtask

   // one lone instruction walks the stages, one per machine cycle
   task automatic t_pipeline();
      repeat (8) @(posedge core_clk);
      #5;
      wait_ready();
      instrValid = 1'b1;
      instrOp = dict_pkg::OP_ZERO_PRODUCT_REG;
      @(posedge core_clk);
      #5;
      instrValid = 1'b0;
      for (int k = 0; k < STG; k++) begin
         check(stageValid === STG'(1 << k), "stage walk");
         if (k == STG - 1) check(execOp === dict_pkg::OP_ZERO_PRODUCT_REG, "exec op");
         @(posedge core_clk);
         #5;
      end
   endtask

   // bound reckoned from 57 issues of at most eight edges each
   initial begin
      #(20000 * 50);
      err_count++;
      stop_test();
   end

   initial begin
      reset_n = 1'b0;
      clkDivOnePin = 1'b0;
      instrValid = 1'b0;
      instrOp = dict_pkg::OP_IDLE;
      repeatPending = 1'b0;
      t_reset();
      for (int i = 1; i <= 28; i++) issue(i, 1'b0);
      t_div_one();
      for (int i = 1; i <= 28; i++) issue(i, 1'b1);
      t_pipeline();
      clkDivOnePin = 1'b0;
      t_reset();
      issue(25, 1'b0);
      stop_test();
   end
endmodule // dict_top_tb_top
`default_nettype wire
